// *** core_state_pkg.sv ***
package core_state_pkg;

  typedef logic [31:0] word_t;

  // register map: byte offset = group * 0x40 + word * 4
  localparam logic [3:0] GRP_CUR    = 4'h0;
  localparam logic [3:0] GRP_NS     = 4'h1;
  localparam logic [3:0] GRP_GPR    = 4'h2;
  localparam logic [3:0] GRP_FP0    = 4'h4;
  localparam logic [3:0] GRP_FP1    = 4'h5;
  localparam logic [3:0] W_STATUS   = 4'h0;
  localparam logic [3:0] W_CTRL     = 4'h1;
  localparam logic [3:0] W_MSP      = 4'h2;
  localparam logic [3:0] W_PSP      = 4'h3;
  localparam logic [3:0] W_MLIM     = 4'h4;
  localparam logic [3:0] W_PLIM     = 4'h5;
  localparam logic [3:0] W_PRIO     = 4'h6;
  localparam logic [3:0] W_THR      = 4'h7;
  localparam logic [3:0] W_ALLB     = 4'h8;
  localparam logic [3:0] W_CURSP    = 4'h9;
  localparam logic [3:0] W_PSR      = 4'ha;
  localparam logic [3:0] GPR_SP     = 4'hd;
  localparam logic [3:0] GPR_PC     = 4'hf;

  localparam int ST_HANDLER = 0;
  localparam int ST_PRIV    = 1;
  localparam int ST_SECURE  = 2;
  localparam int ST_DEBUG   = 3;
  localparam int ST_MONITOR = 4;
  localparam int ST_PROC_SP = 5;
  localparam int CTRL_NPRIV = 0;
  localparam int CTRL_SPSEL = 1;

  localparam logic       BANK_NS     = 1'b0;
  localparam logic       BANK_S      = 1'b1;
  localparam logic [1:0] FP_SINGLE   = 2'h0;
  localparam logic [1:0] FP_DOUBLE   = 2'h1;
  localparam logic [1:0] FP_VECTOR   = 2'h2;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  localparam logic       HRESP_OKAY  = 1'b0;
  localparam logic       RST_HREADY  = 1'b1;
  localparam logic [4:0] WIDE_PREFIX = 5'h1d;

  typedef enum logic {OPS_COMPACT, OPS_DEBUG} opstate_e;

  typedef struct packed {
    word_t control;
    word_t all_block;
    word_t threshold;
    word_t prio_block;
    word_t proc_lim;
    word_t main_lim;
    word_t proc_sp;
    word_t main_sp;
  } bank_s;

  typedef struct packed {
    logic       take;
    logic       tgt_secure;
    logic [8:0] num;
    logic       ret;
    logic       ret_thread;
    logic       ret_secure;
    logic [8:0] ret_num;
  } exc_evt_s;

  typedef struct packed {
    logic ld_done;
    logic ld_exokay;
    logic ld_tcm;
    logic st_req;
    logic clr;
  } excl_evt_s;

  typedef struct packed {
    logic       valid;
    logic       nmi;
    logic       sec_hardfault;
    logic       configurable;
    logic [7:0] pri;
  } gate_req_s;

endpackage

// *** core_mode_exclusive_monitor.sv ***
`timescale 1ns/1ps
// Overview of operation
// - reset or return to thread enters thread
// - taking any exception enters handler mode
// - handler privileged; thread privilege per control
// - secure exception from non-secure enters secure handler
// - decode 16/32-bit halfword-aligned compact instructions
// - halting debug enters separate debug state
// - monitor holds no address, any store matches
// - reservation granule is whole address range
// - plain OKAY exclusive read leaves monitor clear
// - store without monitor: no transaction, reports 1
// - tightly coupled memory exclusives via local monitor only
// - bus carries exclusives for a system monitor
// - every core register is 32 bits
// - secure bank visible only in secure state
// - thread r13 is main or process pointer
// - banked limits bound each stack pointer
// - priority block masks configurable exceptions
// - threshold passes only higher priority exceptions
// - all-exception block leaves nmi, optional hard fault
// - loop tracking state has no software path
// - 32 singles viewed as 16 doubles, 8 vectors
// - reset secure if security present, else non-secure
module core_mode_exclusive_monitor #(
  parameter int unsigned SECURITY_EN = 1,
  parameter int unsigned HF_ESCAPE   = 1
) (
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic                      hready,
  input  wire logic [31:0]               hwdata,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire core_state_pkg::exc_evt_s  exc_evt,
  input  wire logic                      halt_req,
  input  wire logic                      resume_req,
  input  wire logic                      instr_valid,
  input  wire logic [15:0]               instr_hw,
  input  wire logic                      instr_addr_lsb,
  input  wire core_state_pkg::excl_evt_s excl_evt,
  input  wire core_state_pkg::gate_req_s gate_req,
  input  wire logic                      loop_track_we,
  input  wire logic [31:0]               loop_track_val,
  input  wire logic [1:0]                fp_rd_view,
  input  wire logic [4:0]                fp_rd_idx,
  output logic                           handler_mode,
  output logic                           privileged,
  output logic                           secure_state,
  output logic                           debug_state,
  output logic                           monitor_set,
  output logic                           sp_is_process,
  output logic [31:0]                    current_sp,
  output logic                           strex_go,
  output logic                           strex_fail,
  output logic                           stack_limit_fault,
  output logic                           exc_allowed,
  output logic                           instr_is_32,
  output logic                           fetch_align_fault,
  output logic [31:0]                    loop_tracking_state,
  output logic [127:0]                   fp_rd_data
);

  if (SECURITY_EN > 1 || HF_ESCAPE > 1) begin : g_param_check
    $error("SECURITY_EN and HF_ESCAPE must be 0 or 1");
  end

  typedef struct packed {
    core_state_pkg::bank_s [1:0]   banks;
    core_state_pkg::word_t [15:0]  gpr;
    core_state_pkg::word_t [31:0]  fpr;
    core_state_pkg::word_t         psr;
    core_state_pkg::word_t         loop_track;
    core_state_pkg::opstate_e      opstate;
    logic                          handler;
    logic                          secure;
    logic                          priv;
    logic                          sp_proc;
    core_state_pkg::word_t         cur_sp;
    logic                          monitor;
    logic                          strex_go;
    logic                          strex_fail;
    logic                          lim_fault;
    logic                          exc_ok;
    logic                          instr32;
    logic                          align_fault;
    logic [127:0]                  fp_data;
    logic                          wr_pend;
    logic [9:0]                    wr_addr;
    core_state_pkg::word_t         rdata;
    logic                          rdy;
  } state_s;

  state_s q;
  state_s d;

  // without the security option only the non-secure bank is ever used
  function automatic logic cur_bank(input logic sec);
    cur_bank = (SECURITY_EN != 0) ? sec : core_state_pkg::BANK_NS;
  endfunction

  function automatic core_state_pkg::word_t bank_rd(
    input core_state_pkg::bank_s b,
    input logic [3:0]            w
  );
    case (w)
      core_state_pkg::W_CTRL: bank_rd = b.control;
      core_state_pkg::W_MSP:  bank_rd = b.main_sp;
      core_state_pkg::W_PSP:  bank_rd = b.proc_sp;
      core_state_pkg::W_MLIM: bank_rd = b.main_lim;
      core_state_pkg::W_PLIM: bank_rd = b.proc_lim;
      core_state_pkg::W_PRIO: bank_rd = b.prio_block;
      core_state_pkg::W_THR:  bank_rd = b.threshold;
      core_state_pkg::W_ALLB: bank_rd = b.all_block;
      default:                bank_rd = 32'h0;
    endcase
  endfunction

  // lower number is higher priority; zero threshold disables masking
  function automatic logic thr_blocks(
    input core_state_pkg::word_t thr,
    input logic [7:0]            pri
  );
    thr_blocks = (thr[7:0] != 8'h00) && (pri >= thr[7:0]);
  endfunction

  function automatic core_state_pkg::word_t read_word(
    input state_s     s,
    input logic [9:0] a
  );
    logic [3:0] g;
    logic [3:0] w;
    logic       b;
    g = a[9:6];
    w = a[5:2];
    b = (g == core_state_pkg::GRP_NS) ? core_state_pkg::BANK_NS
                                      : cur_bank(s.secure);
    read_word = 32'h0;
    case (g)
      core_state_pkg::GRP_CUR: begin
        case (w)
          core_state_pkg::W_STATUS: begin
            read_word[core_state_pkg::ST_HANDLER] = s.handler;
            read_word[core_state_pkg::ST_PRIV]    = s.priv;
            read_word[core_state_pkg::ST_SECURE]  = s.secure;
            read_word[core_state_pkg::ST_DEBUG]   =
              (s.opstate == core_state_pkg::OPS_DEBUG);
            read_word[core_state_pkg::ST_MONITOR] = s.monitor;
            read_word[core_state_pkg::ST_PROC_SP] = s.sp_proc;
          end
          core_state_pkg::W_CURSP: read_word = s.cur_sp;
          core_state_pkg::W_PSR:   read_word = s.psr;
          default:                 read_word = bank_rd(s.banks[b], w);
        endcase
      end
      core_state_pkg::GRP_NS:  read_word = bank_rd(s.banks[b], w);
      core_state_pkg::GRP_GPR:
        read_word = (w == core_state_pkg::GPR_SP) ? s.cur_sp : s.gpr[w];
      core_state_pkg::GRP_FP0, core_state_pkg::GRP_FP1:
        read_word = s.fpr[{g[0], w}];
      default: read_word = 32'h0;
    endcase
  endfunction

  logic                  acc;
  logic [3:0]            wg;
  logic [3:0]            ww;
  logic                  wb;
  logic                  sp_wr;
  logic                  sp_to_proc;
  core_state_pkg::word_t sp_lim;
  logic                  blk_prio;
  logic                  blk_thr;
  logic                  blk_all;
  logic                  mon_set;
  logic                  cb;

  always_comb begin
    d            = q;
    d.strex_go   = 1'b0;
    d.strex_fail = 1'b0;
    d.lim_fault  = 1'b0;
    sp_wr        = 1'b0;
    sp_to_proc   = 1'b0;
    sp_lim       = 32'h0;
    wg           = q.wr_addr[9:6];
    ww           = q.wr_addr[5:2];
    wb = (wg == core_state_pkg::GRP_NS) ? core_state_pkg::BANK_NS
                                        : cur_bank(q.secure);
    // data phase of a write; control, limit, mask, psr, pc and sp writes keep only some of the 32 bits
    if (q.wr_pend) begin
      case (wg)
        core_state_pkg::GRP_CUR, core_state_pkg::GRP_NS: begin
          case (ww)
            core_state_pkg::W_CTRL:
              d.banks[wb].control = {30'h0, hwdata[1:0]};
            core_state_pkg::W_MSP: sp_wr = 1'b1;
            core_state_pkg::W_PSP: begin
              sp_wr      = 1'b1;
              sp_to_proc = 1'b1;
            end
            core_state_pkg::W_MLIM:
              d.banks[wb].main_lim = {hwdata[31:3], 3'h0};
            core_state_pkg::W_PLIM:
              d.banks[wb].proc_lim = {hwdata[31:3], 3'h0};
            core_state_pkg::W_PRIO:
              d.banks[wb].prio_block = {31'h0, hwdata[0]};
            core_state_pkg::W_THR:
              d.banks[wb].threshold = {24'h0, hwdata[7:0]};
            core_state_pkg::W_ALLB:
              d.banks[wb].all_block = {31'h0, hwdata[0]};
            core_state_pkg::W_CURSP: begin
              sp_wr      = (wg == core_state_pkg::GRP_CUR);
              sp_to_proc = q.sp_proc;
            end
            core_state_pkg::W_PSR:
              // only the application flags are software writable
              if (wg == core_state_pkg::GRP_CUR) begin
                d.psr[31:27] = hwdata[31:27];
              end
            default: d.psr = q.psr;
          endcase
        end
        core_state_pkg::GRP_GPR: begin
          if (ww == core_state_pkg::GPR_SP) begin
            sp_wr      = 1'b1;
            sp_to_proc = q.sp_proc;
          end else if (ww == core_state_pkg::GPR_PC) begin
            d.gpr[ww] = {hwdata[31:1], 1'b0};
          end else begin
            d.gpr[ww] = hwdata;
          end
        end
        core_state_pkg::GRP_FP0, core_state_pkg::GRP_FP1:
          d.fpr[{wg[0], ww}] = hwdata;
        default: d.psr = q.psr;
      endcase
    end
    // a pointer below its limit is refused and flagged, not clipped
    if (sp_wr) begin
      sp_lim = sp_to_proc ? q.banks[wb].proc_lim : q.banks[wb].main_lim;
      if (hwdata < sp_lim) begin
        d.lim_fault = 1'b1;
      end else if (sp_to_proc) begin
        d.banks[wb].proc_sp = {hwdata[31:2], 2'h0};
      end else begin
        d.banks[wb].main_sp = {hwdata[31:2], 2'h0};
      end
    end

    // exception entry wins over a return in the same cycle
    if (exc_evt.take) begin
      d.handler  = 1'b1;
      d.psr[8:0] = exc_evt.num;
      if (SECURITY_EN != 0) begin
        d.secure = exc_evt.tgt_secure;
      end
    end else if (exc_evt.ret) begin
      d.handler  = ~exc_evt.ret_thread;
      d.psr[8:0] = exc_evt.ret_thread ? 9'h000 : exc_evt.ret_num;
      if (SECURITY_EN != 0) begin
        d.secure = exc_evt.ret_secure;
      end
    end

    case (q.opstate)
      core_state_pkg::OPS_COMPACT:
        if (halt_req) begin
          d.opstate = core_state_pkg::OPS_DEBUG;
        end
      core_state_pkg::OPS_DEBUG:
        if (resume_req) begin
          d.opstate = core_state_pkg::OPS_COMPACT;
        end
      default: d.opstate = core_state_pkg::OPS_COMPACT;
    endcase

    // no decode while halted; wide encodings start 0b11101..0b11111
    // a halt in the same cycle already stops the decode
    d.instr32 = instr_valid && (d.opstate == core_state_pkg::OPS_COMPACT)
                && (instr_hw[15:11] >= core_state_pkg::WIDE_PREFIX);
    d.align_fault = instr_valid && instr_addr_lsb
                    && (d.opstate == core_state_pkg::OPS_COMPACT);

    // no address is kept, so any store-exclusive matches the last load;
    // a set arriving with a clear is kept
    mon_set = excl_evt.ld_done
              && (excl_evt.ld_exokay || excl_evt.ld_tcm);
    if (excl_evt.st_req) begin
      d.strex_go   = q.monitor;
      d.strex_fail = ~q.monitor;
    end
    d.monitor = mon_set
                || (q.monitor && !(excl_evt.st_req || excl_evt.clr));

    if (loop_track_we) begin
      d.loop_track = loop_track_val;
    end

    // masks of both banks apply whatever the current state
    blk_prio = q.banks[0].prio_block[0] || q.banks[1].prio_block[0];
    blk_thr  = thr_blocks(q.banks[0].threshold, gate_req.pri)
               || thr_blocks(q.banks[1].threshold, gate_req.pri);
    blk_all  = (q.banks[0].all_block[0] || q.banks[1].all_block[0])
               && !(gate_req.sec_hardfault && (HF_ESCAPE != 0));
    d.exc_ok = gate_req.valid && (gate_req.nmi
               || (!blk_all
                   && !(gate_req.configurable && blk_prio)
                   && !(gate_req.configurable && blk_thr)));

    case (fp_rd_view)
      core_state_pkg::FP_SINGLE: d.fp_data = {96'h0, q.fpr[fp_rd_idx]};
      core_state_pkg::FP_DOUBLE:
        d.fp_data = {64'h0, q.fpr[{fp_rd_idx[3:0], 1'b1}],
                     q.fpr[{fp_rd_idx[3:0], 1'b0}]};
      core_state_pkg::FP_VECTOR:
        d.fp_data = {q.fpr[{fp_rd_idx[2:0], 2'h3}],
                     q.fpr[{fp_rd_idx[2:0], 2'h2}],
                     q.fpr[{fp_rd_idx[2:0], 2'h1}],
                     q.fpr[{fp_rd_idx[2:0], 2'h0}]};
      default: d.fp_data = 128'h0;
    endcase

    cb        = cur_bank(d.secure);
    d.priv    = d.handler
                || !d.banks[cb].control[core_state_pkg::CTRL_NPRIV];
    d.sp_proc = !d.handler
                && d.banks[cb].control[core_state_pkg::CTRL_SPSEL];
    d.cur_sp  = d.sp_proc ? d.banks[cb].proc_sp : d.banks[cb].main_sp;

    // reads see this cycle's write, so a read after a write is current
    acc       = hsel && htrans[1] && hready
                && (hsize == core_state_pkg::HSIZE_WORD)
                && (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    d.wr_pend = acc && hwrite;
    d.wr_addr = haddr[9:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      d.rdata = acc ? read_word(d, haddr[9:0]) : 32'h0;
    end
    d.rdy = core_state_pkg::RST_HREADY;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q         <= '0;
      q.secure  <= (SECURITY_EN != 0);
      q.priv    <= 1'b1;
      q.rdy     <= core_state_pkg::RST_HREADY;
    end else begin
      q <= d;
    end
  end

  assign hrdata              = q.rdata;
  assign hreadyout           = q.rdy;
  assign hresp               = core_state_pkg::HRESP_OKAY;
  assign handler_mode        = q.handler;
  assign privileged          = q.priv;
  assign secure_state        = q.secure;
  assign debug_state         = (q.opstate == core_state_pkg::OPS_DEBUG);
  assign monitor_set         = q.monitor;
  assign sp_is_process       = q.sp_proc;
  assign current_sp          = q.cur_sp;
  assign strex_go            = q.strex_go;
  assign strex_fail          = q.strex_fail;
  assign stack_limit_fault   = q.lim_fault;
  assign exc_allowed         = q.exc_ok;
  assign instr_is_32         = q.instr32;
  assign fetch_align_fault   = q.align_fault;
  assign loop_tracking_state = q.loop_track;
  assign fp_rd_data          = q.fp_data;

  default clocking cb_core @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_excl_load_ok;
    excl_evt.ld_done && excl_evt.ld_exokay && !excl_evt.st_req;
  endsequence

  sequence s_store_next;
    excl_evt.st_req && !excl_evt.clr;
  endsequence

  sequence s_excl_quiet;
    !excl_evt.st_req && !excl_evt.clr;
  endsequence

  a_return_thread: assert property (
    exc_evt.ret && exc_evt.ret_thread && !exc_evt.take |=> !handler_mode)
    else $error("return to thread left handler mode set");
  a_take_handler: assert property (
    exc_evt.take |=> handler_mode && privileged)
    else $error("exception taken without handler mode");
  a_handler_priv: assert property (
    handler_mode |-> privileged)
    else $error("handler mode running unprivileged");
  a_secure_entry: assert property (
    exc_evt.take && exc_evt.tgt_secure && !secure_state
    && (SECURITY_EN != 0) |=> secure_state && handler_mode)
    else $error("secure exception did not enter secure handler");
  a_halt_enter: assert property (
    halt_req && !debug_state |=> debug_state && !instr_is_32)
    else $error("halt request did not enter debug state");
  a_excl_pass: assert property (
    s_excl_load_ok ##1 s_store_next |=> strex_go && !strex_fail)
    else $error("store after exclusive load did not proceed");
  a_excl_kept: assert property (
    s_excl_load_ok ##1 s_excl_quiet ##1 s_store_next
    |=> strex_go && !strex_fail)
    else $error("store two cycles after exclusive load failed");
  a_okay_unset: assert property (
    excl_evt.ld_done && !excl_evt.ld_exokay && !excl_evt.ld_tcm
    && !monitor_set |=> !monitor_set)
    else $error("plain okay response set the monitor");
  a_strex_fail: assert property (
    excl_evt.st_req && !monitor_set |=> strex_fail && !strex_go)
    else $error("store without monitor was issued");
  a_sp_select: assert property (
    handler_mode |-> !sp_is_process)
    else $error("handler mode using the process stack");
  a_prio_block: assert property (
    gate_req.configurable && !gate_req.nmi
    && (q.banks[0].prio_block[0] || q.banks[1].prio_block[0])
    |=> !exc_allowed)
    else $error("configurable exception passed priority block");
  a_nmi_pass: assert property (
    gate_req.valid && gate_req.nmi |=> exc_allowed)
    else $error("non-maskable interrupt was blocked");
  a_reset_clear: assert property (
    $rose(hresetn) |-> !monitor_set)
    else $error("monitor set after reset");

endmodule

// *** excl_bus_model.sv ***
`timescale 1ns/1ps
// far side of the load/store path: answers exclusive reads late or early
module excl_bus_model (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ld_req,
  input  wire logic                 slow,
  input  wire logic                 global_mon,
  input  wire logic                 tcm,
  input  wire logic                 st_req,
  input  wire logic                 clr,
  input  wire logic                 strex_go,
  output core_state_pkg::excl_evt_s excl_evt,
  output logic [7:0]                store_cnt
);
  logic [2:0] cnt_q;
  logic       done_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q     <= 3'h0;
      done_q    <= 1'b0;
      store_cnt <= 8'h00;
    end else begin
      done_q <= (cnt_q == 3'h1);
      if (ld_req) begin
        cnt_q <= slow ? 3'h4 : 3'h1;
      end else if (cnt_q != 3'h0) begin
        cnt_q <= cnt_q - 3'h1;
      end
      if (strex_go) begin
        store_cnt <= store_cnt + 8'h01;
      end
    end
  end

  // a region with no global monitor must not claim exclusive success
  assign excl_evt.ld_done   = done_q;
  assign excl_evt.ld_exokay = done_q & global_mon & ~tcm;
  assign excl_evt.ld_tcm    = done_q & tcm;
  assign excl_evt.st_req    = st_req;
  assign excl_evt.clr       = clr;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]               haddr, hwdata, hrdata, current_sp, rv;
  logic [1:0]                htrans, fp_rd_view;
  logic [2:0]                hsize;
  logic [4:0]                fp_rd_idx;
  logic [127:0]              fp_rd_data;
  logic                      halt_req, resume_req, handler_mode, privileged;
  logic                      secure_state, debug_state, monitor_set, f;
  logic                      sp_is_process, strex_go, strex_fail, exc_allowed;
  logic                      stack_limit_fault, ld_req, slow, global_mon;
  logic                      tcm, st_req, clr;
  logic [7:0]                store_cnt;
  logic                      instr_valid, instr_addr_lsb, instr_is_32;
  logic                      fetch_align_fault, loop_track_we;
  logic [15:0]               instr_hw;
  logic [31:0]               loop_track_val, loop_tracking_state;
  core_state_pkg::exc_evt_s  exc_evt;
  core_state_pkg::excl_evt_s excl_evt;
  core_state_pkg::gate_req_s gate_req;
  int                        error_cnt, samples_checked;

  core_mode_exclusive_monitor #(.SECURITY_EN(1), .HF_ESCAPE(1))
    core_mode_exclusive_monitor_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .exc_evt,
    .halt_req, .resume_req, .instr_valid, .instr_hw, .instr_addr_lsb,
    .excl_evt, .gate_req, .loop_track_we, .loop_track_val, .fp_rd_view,
    .fp_rd_idx, .handler_mode,
    .privileged, .secure_state, .debug_state, .monitor_set, .sp_is_process,
    .current_sp, .strex_go, .strex_fail, .stack_limit_fault, .exc_allowed,
    .instr_is_32, .fetch_align_fault, .loop_tracking_state,
    .fp_rd_data);
  excl_bus_model excl_bus_model_inst (.hclk, .hresetn, .ld_req, .slow,
    .global_mon, .tcm, .st_req, .clr, .strex_go, .excl_evt, .store_cnt);

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) hang();
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, exp);
    bus(1'b0, a, 32'h0);
    chk({hresp, rv}, {core_state_pkg::HRESP_OKAY, exp});
  endtask
  task automatic ins(input logic [15:0] hw, input logic lsb,
                     input logic [1:0] e);
    instr_hw       <= hw;
    instr_addr_lsb <= lsb;
    instr_valid    <= 1'b1;
    tick(1);
    instr_valid <= 1'b0;
    tick(1);
    chk({instr_is_32, fetch_align_fault}, e);
  endtask
  task automatic exc(input logic tk, sec, rth, input logic [8:0] n);
    exc_evt <= '{tk, sec, n, !tk, rth, sec, 9'h000};
    tick(1);
    exc_evt <= '0;
    tick(1);
  endtask
  // slow answers stall the exclusive read for several cycles
  task automatic ldx(input logic s, g, t, exp);
    int n;
    slow       <= s;
    global_mon <= g;
    tcm        <= t;
    ld_req     <= 1'b1;
    tick(1);
    ld_req <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (excl_evt.ld_done !== 1'b1 && n < 20);
    if (n >= 20) hang();
    tick(1);
    chk(monitor_set, exp);
  endtask
  task automatic stx(input logic go);
    st_req <= 1'b1;
    tick(1);
    st_req <= 1'b0;
    tick(1);
    chk({strex_go, strex_fail}, {go, !go});
  endtask
  task automatic gate(input logic [31:0] a, d, input logic [11:0] g,
                      input logic e);
    bus(1'b1, a, d);
    gate_req <= g;
    tick(2);
    chk(exc_allowed, e);
  endtask
  task automatic dbg(input logic h);
    halt_req   <= h;
    resume_req <= !h;
    tick(1);
    halt_req   <= 1'b0;
    resume_req <= 1'b0;
    tick(1);
    chk(debug_state, h);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, halt_req, resume_req, ld_req} = 5'h00;
    {slow, global_mon, tcm, st_req, clr} = 5'h00;
    {haddr, hwdata, htrans, fp_rd_view, fp_rd_idx} = 73'h0;
    {instr_valid, instr_addr_lsb, loop_track_we} = 3'h0;
    {instr_hw, loop_track_val} = 48'h0;
    hsize = core_state_pkg::HSIZE_WORD;
    exc_evt = '0;
    gate_req = '0;
    error_cnt = 0;
    samples_checked = 0;
    tick(5);
    hresetn <= 1'b1;
    chk({handler_mode, monitor_set, debug_state}, 3'h0);
    rd(32'h000, 32'h6);
    stx(1'b0);
    ldx(1'b0, 1'b0, 1'b0, 1'b0);
    stx(1'b0);
    chk(store_cnt, 8'h00);
    ldx(1'b1, 1'b1, 1'b0, 1'b1);
    stx(1'b1);
    tick(1);
    chk(store_cnt, 8'h01);
    ldx(1'b0, 1'b0, 1'b1, 1'b1);
    stx(1'b1);
    bus(1'b1, 32'h010, 32'h1000);
    bus(1'b1, 32'h008, 32'h0ff0);
    f = 1'b0;
    repeat (2) begin
      tick(1);
      f |= stack_limit_fault;
    end
    chk(f, 1'b1);
    bus(1'b1, 32'h008, 32'h2000);
    rd(32'h008, 32'h2000);
    bus(1'b1, 32'h048, 32'h3000);
    exc(1'b1, 1'b0, 1'b0, 9'h00f);
    rd(32'h000, 32'h3);
    rd(32'h028, 32'hf);
    exc(1'b0, 1'b0, 1'b1, 9'h000);
    rd(32'h000, 32'h2);
    chk(current_sp, 32'h3000);
    rd(32'h008, 32'h3000);
    exc(1'b1, 1'b1, 1'b0, 9'h003);
    rd(32'h000, 32'h7);
    exc(1'b0, 1'b1, 1'b1, 9'h000);
    rd(32'h008, 32'h2000);
    bus(1'b1, 32'h00c, 32'h5000);
    bus(1'b1, 32'h004, 32'h3);
    rd(32'h000, 32'h24);
    chk(current_sp, 32'h5000);
    gate(32'h018, 32'h1, 12'h940, 1'b0);
    gate(32'h018, 32'h1, 12'hc40, 1'b1);
    gate(32'h018, 32'h0, 12'h940, 1'b1);
    gate(32'h01c, 32'h40, 12'h940, 1'b0);
    gate(32'h01c, 32'h40, 12'h93f, 1'b1);
    gate(32'h01c, 32'h0, 12'h940, 1'b1);
    gate(32'h020, 32'h1, 12'h910, 1'b0);
    gate(32'h020, 32'h1, 12'hc10, 1'b1);
    gate(32'h020, 32'h1, 12'ha10, 1'b1);
    dbg(1'b1);
    ins(16'hf800, 1'b1, 2'h0);
    dbg(1'b0);
    ins(16'he800, 1'b1, 2'h3);
    ins(16'h4770, 1'b0, 2'h0);
    bus(1'b1, 32'h100, 32'h11111111);
    bus(1'b1, 32'h104, 32'h22222222);
    fp_rd_view <= core_state_pkg::FP_DOUBLE;
    tick(2);
    chk(fp_rd_data, {64'h0, 32'h22222222, 32'h11111111});
    loop_track_val <= 32'h0000abcd;
    loop_track_we  <= 1'b1;
    tick(1);
    loop_track_we <= 1'b0;
    tick(1);
    chk(loop_tracking_state, 32'h0000abcd);
    rd(32'h400, 32'h0);
    stop_test();
  end
endmodule
